// *** common/timer_pkg.sv ***
`default_nettype none

package timer_pkg;

  // One 16-bit count or value field
  typedef logic [15:0] value16_t;

  // One register bus request, sampled each clock
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Per-channel controls from the mode and enable logic outside
  typedef struct packed {
    logic [1:0] input_mode;
    logic [1:0] shadow_en;
    logic [1:0] capture;
  } chan_ctl_t;

  // Event outputs of the block
  typedef struct packed {
    logic update_event;
    logic [1:0] compare_match;
    logic tick;
  } timer_evt_t;

endpackage

`default_nettype wire

// *** common/timer_regs_map.svh ***
`ifndef TIMER_REGS_MAP_SVH
`define TIMER_REGS_MAP_SVH

// Byte offsets of the register words
`define OFS_COUNTER_VALUE 8'h24
`define OFS_CLOCK_DIVIDER 8'h28
`define OFS_RELOAD_LIMIT 8'h2C
`define OFS_CHAN0_COMPARE_CAPTURE 8'h34
`define OFS_CHAN1_COMPARE_CAPTURE 8'h38
`define OFS_WRITE_FILTER_CONFIG 8'hFC

// Field positions
`define VALUE_FIELD_MSB 15
`define VALUE_FIELD_LSB 0
`define FILTER_BIT_POS 1

// Reset values
`define RESET_WORD 32'h0000_0000
`define RESET_VALUE16 16'h0000
`define RESET_BIT 1'h0

// Step sizes: prescaler per kernel clock cycle, count per divided tick
`define PRESCALE_STEP 16'h0001
`define COUNT_STEP 16'h0001

`endif

// *** design/chan_value_slot.sv ***
`default_nettype none

`include "timer_regs_map.svh"

module chan_value_slot
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic write_hit,
  input wire timer_pkg::value16_t write_data,
  input wire logic filter_en,
  input wire logic input_mode,
  input wire logic capture,
  input wire timer_pkg::value16_t count,
  input wire logic shadow_en,
  input wire logic update_fire,
  output logic [15:0] value,
  output logic [15:0] active
);
  import timer_pkg::*;

  value16_t value_reg;
  value16_t value_next;
  value16_t active_reg;
  logic write_take;

  // Equal writes are dropped only while the filter is on
  assign write_take = write_hit && !(filter_en && (write_data == value_reg)); // [RULE10]

  // Capture in input mode, software load in output mode
  always_comb
  begin
    value_next = value_reg;
    if (input_mode)
    begin
      if (capture)
      begin
        value_next = count; // [RULE7]
      end
    end
    else if (write_take)
    begin
      value_next = write_data; // [RULE8]
    end
  end

  // Software-visible value field
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      value_reg <= `RESET_VALUE16;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  // Active compare copy; without shadowing it tracks the field at once
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      active_reg <= `RESET_VALUE16;
    end
    else if (!shadow_en)
    begin
      active_reg <= value_next;
    end
    else if (update_fire)
    begin
      active_reg <= value_reg; // [RULE9]
    end
  end

  assign value = value_reg;
  assign active = active_reg;

endmodule

`default_nettype wire

// *** design/timer_counter_compare_regs.sv ***
// Functional notes
// RULE1: Software reaches every register with whole 32-bit word transfers only.
// RULE2: Reading the counter register gives the live 16-bit count with zero upper bits.
// RULE3: Writing the counter register replaces the running count with the written value.
// RULE4: The counting clock is the kernel clock divided by the divider setting plus one.
// RULE5: A new divider setting is copied to a shadow at each update event and only then used.
// RULE6: A 16-bit read/write reload field holds the counter's reload limit.
// RULE7: In input mode a channel value holds the count from its last capture, read-only.
// RULE8: In output mode a channel value holds the figure compared against the count.
// RULE9: With shadowing on, the written compare value becomes active only at an update event.
// RULE10: With the filter bit set, a channel write equal to the stored value is ignored.
// RULE11: Software alone sets and clears the filter bit; hardware never changes it.
// RULE12: Software writes reserved bit positions as zero.
// RULE13: The count rises per divided tick, wraps to zero at the reload value, and updates.
//
// Chosen here: the plain strobed port.

`default_nettype none

`include "timer_regs_map.svh"

module timer_counter_compare_regs
(
  input wire logic clock,
  input wire logic nrst,
  input wire timer_pkg::bus_req_t bus_req,
  input wire timer_pkg::chan_ctl_t chan_ctl,
  input wire logic update_request,
  output logic [31:0] rd_data,
  output timer_pkg::timer_evt_t events,
  output logic [15:0] count_out
);
  import timer_pkg::*;

  // Register storage
  value16_t count_reg;
  value16_t count_next;
  value16_t prescale_reg;
  value16_t prescale_next;
  value16_t divider_reg;
  value16_t divider_shadow_reg;
  value16_t reload_reg;
  logic filter_reg;
  logic [31:0] rd_data_reg;
  logic [31:0] read_word;
  timer_evt_t events_reg;
  timer_evt_t events_next;

  // Bus decode strobes
  logic wr_count;
  logic wr_divider;
  logic wr_reload;
  logic wr_chan0;
  logic wr_chan1;
  logic wr_filter;
  value16_t wdata16;

  // Counting strobes
  logic tick;
  logic wrap;
  logic update_fire;

  // Channel value fields and their active copies
  value16_t chan0_value;
  value16_t chan1_value;
  value16_t chan0_active;
  value16_t chan1_active;

  // Whole-word decode; byte lanes do not exist on this port
  assign wr_count = bus_req.wr && (bus_req.addr == `OFS_COUNTER_VALUE); // [RULE1]
  assign wr_divider = bus_req.wr && (bus_req.addr == `OFS_CLOCK_DIVIDER);
  assign wr_reload = bus_req.wr && (bus_req.addr == `OFS_RELOAD_LIMIT);
  assign wr_chan0 = bus_req.wr && (bus_req.addr == `OFS_CHAN0_COMPARE_CAPTURE);
  assign wr_chan1 = bus_req.wr && (bus_req.addr == `OFS_CHAN1_COMPARE_CAPTURE);
  assign wr_filter = bus_req.wr && (bus_req.addr == `OFS_WRITE_FILTER_CONFIG);

  // Upper data bits are dropped, so reserved positions store nothing
  assign wdata16 = bus_req.wdata[`VALUE_FIELD_MSB:`VALUE_FIELD_LSB]; // [RULE12]

  // A tick ends each prescaler period of divider plus one cycles
  assign tick = (prescale_reg == divider_shadow_reg); // [RULE4]

  // A software count write in the same cycle takes precedence over the wrap
  assign wrap = tick && (count_reg == reload_reg) && !wr_count; // [RULE13]

  // Update comes from the wrap or from the outside update request
  assign update_fire = wrap || update_request;

  // Prescaler phase counter
  always_comb
  begin
    prescale_next = prescale_reg + `PRESCALE_STEP;
    if (update_request || tick)
    begin
      prescale_next = `RESET_VALUE16; // [RULE4]
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      prescale_reg <= `RESET_VALUE16;
    end
    else
    begin
      prescale_reg <= prescale_next;
    end
  end

  // Divider setting as written by software
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      divider_reg <= `RESET_VALUE16;
    end
    else if (wr_divider)
    begin
      divider_reg <= wdata16;
    end
  end

  // Shadow divider; changing it mid-period would give one odd period
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      divider_shadow_reg <= `RESET_VALUE16;
    end
    else if (update_fire)
    begin
      divider_shadow_reg <= divider_reg; // [RULE5]
    end
  end

  // Reload limit
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      reload_reg <= `RESET_VALUE16;
    end
    else if (wr_reload)
    begin
      reload_reg <= wdata16; // [RULE6]
    end
  end

  // Filter bit changes only on a software write
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      filter_reg <= `RESET_BIT;
    end
    else if (wr_filter)
    begin
      filter_reg <= bus_req.wdata[`FILTER_BIT_POS]; // [RULE11]
    end
  end

  // Next count: software write, then forced update, then the tick
  always_comb
  begin
    count_next = count_reg;
    if (wr_count)
    begin
      count_next = wdata16; // [RULE3]
    end
    else if (update_request)
    begin
      count_next = `RESET_VALUE16;
    end
    else if (tick)
    begin
      if (wrap)
      begin
        count_next = `RESET_VALUE16; // [RULE13]
      end
      else
      begin
        count_next = count_reg + `COUNT_STEP; // [RULE13]
      end
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= `RESET_VALUE16;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  // Channel 0 value field and compare copy
  chan_value_slot u_chan0
  (
    .clock(clock),
    .nrst(nrst),
    .write_hit(wr_chan0),
    .write_data(wdata16),
    .filter_en(filter_reg),
    .input_mode(chan_ctl.input_mode[0]),
    .capture(chan_ctl.capture[0]),
    .count(count_reg),
    .shadow_en(chan_ctl.shadow_en[0]),
    .update_fire(update_fire),
    .value(chan0_value),
    .active(chan0_active)
  );

  // Channel 1 value field and compare copy
  chan_value_slot u_chan1
  (
    .clock(clock),
    .nrst(nrst),
    .write_hit(wr_chan1),
    .write_data(wdata16),
    .filter_en(filter_reg),
    .input_mode(chan_ctl.input_mode[1]),
    .capture(chan_ctl.capture[1]),
    .count(count_reg),
    .shadow_en(chan_ctl.shadow_en[1]),
    .update_fire(update_fire),
    .value(chan1_value),
    .active(chan1_active)
  );

  // Event outputs, registered so they leave the block from flops
  always_comb
  begin
    events_next = '0;
    events_next.update_event = update_fire; // [RULE13]
    events_next.tick = tick;
    // Match only for output-mode channels; a captured value is not a target
    events_next.compare_match[0] = !chan_ctl.input_mode[0]
      && (count_reg == chan0_active); // [RULE8]
    events_next.compare_match[1] = !chan_ctl.input_mode[1]
      && (count_reg == chan1_active); // [RULE8]
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      events_reg <= '0;
    end
    else
    begin
      events_reg <= events_next;
    end
  end

  // Read mux; unmapped offsets and reserved bits read as zero
  always_comb
  begin
    read_word = `RESET_WORD;
    case (bus_req.addr)
      `OFS_COUNTER_VALUE:
      begin
        read_word = {16'h0000, count_reg}; // [RULE2]
      end
      `OFS_CLOCK_DIVIDER:
      begin
        read_word = {16'h0000, divider_reg};
      end
      `OFS_RELOAD_LIMIT:
      begin
        read_word = {16'h0000, reload_reg}; // [RULE6]
      end
      `OFS_CHAN0_COMPARE_CAPTURE:
      begin
        read_word = {16'h0000, chan0_value}; // [RULE7]
      end
      `OFS_CHAN1_COMPARE_CAPTURE:
      begin
        read_word = {16'h0000, chan1_value}; // [RULE7]
      end
      `OFS_WRITE_FILTER_CONFIG:
      begin
        read_word = `RESET_WORD;
        read_word[`FILTER_BIT_POS] = filter_reg;
      end
      default:
      begin
        read_word = `RESET_WORD;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_data_reg <= `RESET_WORD;
    end
    else if (bus_req.rd)
    begin
      rd_data_reg <= read_word;
    end
    else
    begin
      rd_data_reg <= `RESET_WORD;
    end
  end

  assign rd_data = rd_data_reg;
  assign events = events_reg;
  assign count_out = count_reg;

endmodule

`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  logic clock;
  logic nrst;
  logic update_request;
  bus_req_t req;
  chan_ctl_t ctl;
  logic [31:0] rd_data;
  timer_evt_t events;
  logic [15:0] count_out;
  logic [31:0] got;
  logic [15:0] c0;
  int n_errors = 0;
  int checks_done = 0;
  // Rows: address, word written, word read back (last row unmapped)
  // Filter is on while the channels take unequal words, so they must still land
  logic [7:0] ra [7] = '{8'h2C, 8'h28, 8'hFC, 8'h34, 8'h38, 8'hFC, 8'h40};
  logic [31:0] rw [7] = '{32'h1234, 32'h3, 32'h2, 32'h55AA, 32'hF0F, 32'h0, 32'h1};
  logic [31:0] re [7] = '{32'h1234, 32'h3, 32'h2, 32'h55AA, 32'hF0F, 32'h0, 32'h0};

  timer_counter_compare_regs u_dut
  (
    .clock(clock),
    .nrst(nrst),
    .bus_req(req),
    .chan_ctl(ctl),
    .update_request(update_request),
    .rd_data(rd_data),
    .events(events),
    .count_out(count_out)
  );

  // 100 MHz kernel clock
  always #5 clock = ~clock;

  // One bus cycle; read data sampled mid-cycle to stay clear of the edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{a, d, w, !w};
    @(posedge clock);
    req <= '0;
    @(negedge clock);
    got = rd_data;
    @(posedge clock);
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Update pulse, also reloads the divider shadow
  task automatic pulse();
    update_request <= 1'b1;
    @(posedge clock);
    update_request <= 1'b0;
    @(posedge clock);
  endtask

  // Count steps over n cycles; any phase gives the same total when n is a whole number of tick periods
  task automatic rate(input int n, input logic [15:0] e, output logic [15:0] s);
    @(negedge clock);
    c0 = count_out;
    repeat (n) @(negedge clock);
    s = count_out - c0;
    @(posedge clock);
  endtask

  // Bounded wait for a count value
  task automatic wait_cnt(input logic [15:0] v);
    int i = 0;
    do
    begin
      @(negedge clock);
      i++;
    end
    while (count_out !== v && i < 100);
    if (i == 100)
    begin
      n_errors++;
      results();
    end
  endtask

  initial
  begin
    clock = 1'b0;
    nrst = 1'b0;
    update_request = 1'b0;
    req = '0;
    ctl = '0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    // Reset values, then the table
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset value", 32'h0, got);
    end
    for (int i = 0; i < 7; i++)
    begin
      bus(1'b1, ra[i], rw[i]);
      bus(1'b0, ra[i], 32'h0);
      chk("register", re[i], got);
    end
    $display("table test done");
    // Divider 3 waits in its register until an update
    rate(40, 16'h28, c0);
    chk("rate before update", 32'h28, c0);
    pulse();
    rate(40, 16'hA, c0);
    chk("rate after update", 32'hA, c0);
    // Reload 2: count wraps to 0 with an update
    bus(1'b1, 8'h28, 32'h0);
    bus(1'b1, 8'h2C, 32'h2);
    pulse();
    wait_cnt(16'h2);
    @(negedge clock);
    chk("wrap count", 32'h0, count_out);
    chk("wrap update", 32'h1, events.update_event);
    chk("tick running", 32'h1, events.tick);
    $display("counter test done");
    // Widest divider freezes the count so captures are exact
    @(posedge clock);
    bus(1'b1, 8'h28, 32'hFFFF);
    pulse();
    bus(1'b1, 8'h24, 32'hABC);
    bus(1'b0, 8'h24, 32'h0);
    chk("count read", 32'hABC, got);
    ctl <= '{2'b10, 2'b00, 2'b00};
    bus(1'b1, 8'h38, 32'h7777);
    bus(1'b0, 8'h38, 32'h0);
    chk("read-only value", 32'hF0F, got);
    ctl.capture <= 2'b10;
    @(posedge clock);
    ctl.capture <= 2'b00;
    bus(1'b0, 8'h38, 32'h0);
    chk("captured", 32'hABC, got);
    // Shadowed compare value waits for the next update
    ctl.shadow_en <= 2'b01;
    bus(1'b1, 8'h34, 32'hABC);
    repeat (3) @(negedge clock);
    chk("match early", 32'h0, events.compare_match[0]);
    @(posedge clock);
    pulse();
    bus(1'b1, 8'h24, 32'hABC);
    @(negedge clock);
    chk("match", 32'h1, events.compare_match[0]);
    chk("tick frozen", 32'h0, events.tick);
    $display("channel test done");
    // Second reset in mid-run
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(negedge clock);
    chk("count in reset", 32'h0, count_out);
    @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    bus(1'b0, 8'h34, 32'h0);
    chk("value after reset", 32'h0, got);
    $display("reset test done");
    results();
  end
endmodule

bind timer_counter_compare_regs timer_regs_sva u_sva
(
  .clock(clock), .nrst(nrst), .bus_req(bus_req), .chan_ctl(chan_ctl),
  .update_request(update_request), .rd_data(rd_data), .events(events),
  .count_out(count_out)
);

`default_nettype wire

// *** verification/timer_regs_sva.sv ***
`default_nettype none

module timer_regs_sva
(
  input wire logic clock,
  input wire logic nrst,
  input wire timer_pkg::bus_req_t bus_req,
  input wire timer_pkg::chan_ctl_t chan_ctl,
  input wire logic update_request,
  input wire logic [31:0] rd_data,
  input wire timer_pkg::timer_evt_t events,
  input wire logic [15:0] count_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  default clocking @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Software write to the counter, which overrides any wrap
  logic cnt_wr;
  assign cnt_wr = bus_req.wr && bus_req.addr == 8'h24;

  // Bus read side, and the counter write
  rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 32'h0)
    else $error("read data not idle");
  cnt_read_a: assert property ($past(bus_req.rd && bus_req.addr == 8'h24)
    |-> rd_data == {16'h0, $past(count_out)})
    else $error("counter read wrong");
  cnt_write_a: assert property (cnt_wr |=> count_out == $past(bus_req.wdata[15:0]))
    else $error("counter write lost");

  // Counting: only step, wrap, update request or software load may move the count
  count_step_a: assert property ($changed(count_out) |-> $past(cnt_wr) ||
    count_out == 16'h0 || count_out == $past(count_out) + 16'h1)
    else $error("count jumped");
  // A count parked above the limit rolls over at the top without an update
  wrap_upd_a: assert property ($fell(|count_out) && !$past(cnt_wr || update_request)
    && $past(count_out) != 16'hFFFF |-> events.update_event)
    else $error("wrap without update");
  upd_req_a: assert property (update_request && !cnt_wr |=>
    events.update_event && count_out == 16'h0)
    else $error("update request ignored");

  // Channel 1: input mode never compares, capture holds the count
  match_in_a: assert property ($past(chan_ctl.input_mode[1]) |-> !events.compare_match[1])
    else $error("match in input mode");
  cap_load_a: assert property (chan_ctl.capture[1] && chan_ctl.input_mode[1] ##1
    bus_req.rd && bus_req.addr == 8'h38 |=> rd_data == {16'h0, $past(count_out, 2)})
    else $error("capture value wrong");

  // Main scenarios reached
  cover property (cnt_wr);
  cover property (events.update_event);
  cover property (chan_ctl.capture[1]);
  cover property (events.compare_match[0]);
endmodule

`default_nettype wire
